// *** verilog/ebzi_pkg.sv ***
// Package: constants for the external bus zone interface
// Assumes: one 10 MHz clock, no register bus; timing comes in as ports
package ebzi_pkg;
    localparam int ADDR_W      = 19;
    localparam int DATA_W      = 16;
    localparam int ZONE_W      = 3;
    localparam int PHASE_W     = 4;
    localparam int SYNC_STAGES = 2;

    // Zone numbers that own a chip select
    localparam logic [2:0] ZONE_0 = 3'h0;
    localparam logic [2:0] ZONE_1 = 3'h1;
    localparam logic [2:0] ZONE_2 = 3'h2;
    localparam logic [2:0] ZONE_6 = 3'h6;
    localparam logic [2:0] ZONE_7 = 3'h7;

    // Reset values
    localparam logic              MODE_RST   = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RST   = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;
    localparam logic [PHASE_W-1:0] CNT_RST   = 4'h0;

    // One-hot access sequencer
    typedef enum logic [4:0] {
        EBZI_IDLE  = 5'h01,
        EBZI_LEAD  = 5'h02,
        EBZI_ACT   = 5'h04,
        EBZI_TRAIL = 5'h08,
        EBZI_HOLD  = 5'h10
    } ebzi_state_e;
endpackage : ebzi_pkg

// *** verilog/ebzi_sync.sv ***
// Holds: two flip-flop level synchroniser
// Assumes: destination clock is the block clock
`timescale 1ns/1ps
module ebzi_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            dout   <= 1'b1;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : ebzi_sync

// *** verilog/ebzi_phase_cnt.sv ***
// Holds: down counter for one strobe phase
// Assumes: load and run come from the sequencer
`timescale 1ns/1ps
module ebzi_phase_cnt (
    // Clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    // Control
    input  wire logic                         load,
    input  wire logic [ebzi_pkg::PHASE_W-1:0] length,
    input  wire logic                         run,
    // Status
    output logic                              done
);
    logic [ebzi_pkg::PHASE_W-1:0] cnt_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= ebzi_pkg::CNT_RST;
        end else if (load) begin
            cnt_q <= length;
        end else if (run && cnt_q != ebzi_pkg::CNT_RST) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // Last cycle of the phase (length 0 or 1 both give one cycle)
    assign done = (cnt_q <= 4'h1);
endmodule : ebzi_phase_cnt

// *** verilog/ebzi_top.sv ***
// Holds: external bus zone interface, pin-level access sequencer
// Assumes: accesses arrive on a valid/ready port; timing per zone as ports
`timescale 1ns/1ps
module ebzi_top (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // Access request
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic                        req_write,
    input  wire logic [ebzi_pkg::ZONE_W-1:0] req_zone,
    input  wire logic [ebzi_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [ebzi_pkg::DATA_W-1:0] req_wdata,
    input  wire logic                        req_pending,
    // Access answer
    output logic                             rsp_valid,
    output logic [ebzi_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                             rsp_boot,
    // Zone timing, all zones side by side
    input  wire logic [8*ebzi_pkg::PHASE_W-1:0] lead_len,
    input  wire logic [8*ebzi_pkg::PHASE_W-1:0] active_len,
    input  wire logic [8*ebzi_pkg::PHASE_W-1:0] trail_len,
    input  wire logic [7:0]                     use_ready,
    input  wire logic [7:0]                     ready_async,
    // Configuration bit for zone 7 mode
    input  wire logic                        mode_wr,
    input  wire logic                        mode_wdata,
    output logic                             ext_bus_config_two,
    // Mode pin
    input  wire logic                        zone_top_mode_select,
    // Hold handshake
    input  wire logic                        bus_hold_request_n,
    output logic                             bus_hold_grant_n,
    // Address bus
    output logic [ebzi_pkg::ADDR_W-1:0]      ext_address_bus_o,
    output logic                             ext_address_bus_oe,
    // Data bus
    input  wire logic [ebzi_pkg::DATA_W-1:0] ext_data_bus_i,
    output logic [ebzi_pkg::DATA_W-1:0]      ext_data_bus_o,
    output logic                             ext_data_bus_oe,
    // Strobes and selects
    output logic                             strobe_oe,
    output logic                             chip_select_low_zones_n,
    output logic                             chip_select_mid_zone_n,
    output logic                             chip_select_high_zones_n,
    output logic                             write_strobe_n,
    output logic                             read_strobe_n,
    output logic                             read_not_write,
    // Ready
    input  wire logic                        access_ready
);
    ebzi_pkg::ebzi_state_e state_q;
    ebzi_pkg::ebzi_state_e state_d;

    logic [ebzi_pkg::ADDR_W-1:0] addr_q;
    logic [ebzi_pkg::DATA_W-1:0] wdata_q;
    logic [ebzi_pkg::DATA_W-1:0] rdata_q;
    logic [ebzi_pkg::ZONE_W-1:0] zone_q;
    logic                        write_q;
    logic                        mode_q;
    logic                        seen_reset_q;
    logic                        rsp_q;
    logic                        boot_q;
    logic                        grant_q;
    logic                        hold_rq_q;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire is_idle  = (state_q == ebzi_pkg::EBZI_IDLE);
    wire in_lead  = (state_q == ebzi_pkg::EBZI_LEAD);
    wire in_act   = (state_q == ebzi_pkg::EBZI_ACT);
    wire in_trail = (state_q == ebzi_pkg::EBZI_TRAIL);
    wire in_hold  = (state_q == ebzi_pkg::EBZI_HOLD);
    wire busy     = in_lead | in_act | in_trail;

    wire req_boot = (req_zone == ebzi_pkg::ZONE_7) && !mode_q;
    wire hold_req = !bus_hold_request_n;

    // grant only when idle and nothing queued
    wire may_grant = is_idle && hold_req && !req_valid && !req_pending;
    assign req_ready = is_idle && !may_grant && !hold_req;
    wire take      = req_valid && req_ready;
    wire start_ext = take && !req_boot;

    wire [ebzi_pkg::PHASE_W-1:0] cur_lead   = lead_len[zone_q*ebzi_pkg::PHASE_W +: 4];
    wire [ebzi_pkg::PHASE_W-1:0] cur_active = active_len[zone_q*ebzi_pkg::PHASE_W +: 4];
    wire [ebzi_pkg::PHASE_W-1:0] cur_trail  = trail_len[zone_q*ebzi_pkg::PHASE_W +: 4];
    wire [ebzi_pkg::PHASE_W-1:0] new_lead   = lead_len[req_zone*ebzi_pkg::PHASE_W +: 4];

    // ****************************************************************
    // Ready sampling
    // ****************************************************************
    logic ready_sync;
    ebzi_sync u_ready_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (access_ready),
        .dout  (ready_sync)
    );
    wire ready_seen = !use_ready[zone_q] ? 1'b1 :
                      (ready_async[zone_q] ? ready_sync : access_ready);

    // ****************************************************************
    // Phase counters
    // ****************************************************************
    logic lead_done;
    logic act_done;
    logic trail_done;
    wire  act_load   = in_lead && lead_done;
    wire  trail_load = in_act && act_done && ready_seen;

    ebzi_phase_cnt u_lead_cnt (
        .clock  (clock),
        .rst_n  (rst_n),
        .load   (start_ext),
        .length (new_lead),
        .run    (in_lead),
        .done   (lead_done)
    );
    ebzi_phase_cnt u_act_cnt (
        .clock  (clock),
        .rst_n  (rst_n),
        .load   (act_load),
        .length (cur_active),
        .run    (in_act),
        .done   (act_done)
    );
    ebzi_phase_cnt u_trail_cnt (
        .clock  (clock),
        .rst_n  (rst_n),
        .load   (trail_load),
        .length (cur_trail),
        .run    (in_trail),
        .done   (trail_done)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ebzi_pkg::EBZI_IDLE: begin
                if (may_grant) begin
                    state_d = ebzi_pkg::EBZI_HOLD;
                end else if (start_ext) begin
                    state_d = ebzi_pkg::EBZI_LEAD;
                end
            end
            ebzi_pkg::EBZI_LEAD: begin
                if (lead_done) begin
                    state_d = ebzi_pkg::EBZI_ACT;
                end
            end
            ebzi_pkg::EBZI_ACT: begin
                if (act_done && ready_seen) begin
                    state_d = ebzi_pkg::EBZI_TRAIL;
                end
            end
            ebzi_pkg::EBZI_TRAIL: begin
                if (trail_done) begin
                    state_d = ebzi_pkg::EBZI_IDLE;
                end
            end
            ebzi_pkg::EBZI_HOLD: begin
                if (!hold_req) begin
                    state_d = ebzi_pkg::EBZI_IDLE;
                end
            end
            default: begin
                state_d = ebzi_pkg::EBZI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ebzi_pkg::EBZI_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Access capture
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_q  <= ebzi_pkg::ADDR_RST;
            wdata_q <= ebzi_pkg::DATA_RST;
            zone_q  <= ebzi_pkg::ZONE_0;
            write_q <= 1'b0;
        end else if (start_ext) begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            zone_q  <= req_zone;
            write_q <= req_write;
        end
    end

    // Read data taken at the end of the active phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= ebzi_pkg::DATA_RST;
            rsp_q   <= 1'b0;
            boot_q  <= 1'b0;
        end else begin
            rsp_q  <= (in_trail && trail_done) || (take && req_boot);
            boot_q <= take && req_boot;
            if (trail_load && !write_q) begin
                rdata_q <= ext_data_bus_i;
            end
        end
    end
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign rsp_boot  = boot_q;

    // ****************************************************************
    // Mode bit
    // ****************************************************************
    // latch pin on first clock after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q       <= ebzi_pkg::MODE_RST;
            seen_reset_q <= 1'b0;
        end else begin
            seen_reset_q <= 1'b1;
            if (!seen_reset_q) begin
                mode_q <= zone_top_mode_select;
            end else if (mode_wr) begin
                mode_q <= mode_wdata;
            end
        end
    end
    assign ext_bus_config_two = mode_q;

    // ****************************************************************
    // Hold grant and pin drive
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            grant_q   <= 1'b0;
            hold_rq_q <= 1'b0;
        end else begin
            grant_q   <= (state_d == ebzi_pkg::EBZI_HOLD);
            hold_rq_q <= hold_req;
        end
    end
    assign bus_hold_grant_n = !grant_q;

    wire drive = !grant_q && !in_hold;
    assign ext_address_bus_o  = addr_q;
    assign ext_address_bus_oe = drive;
    assign strobe_oe          = drive;
    assign ext_data_bus_o     = wdata_q;
    assign ext_data_bus_oe    = drive && busy && write_q;

    assign chip_select_low_zones_n  = !(busy && (zone_q == ebzi_pkg::ZONE_0 ||
                                                 zone_q == ebzi_pkg::ZONE_1));
    assign chip_select_mid_zone_n   = !(busy && zone_q == ebzi_pkg::ZONE_2);
    assign chip_select_high_zones_n = !(busy && (zone_q == ebzi_pkg::ZONE_6 ||
                                                 zone_q == ebzi_pkg::ZONE_7));
    assign write_strobe_n = !(in_act && write_q);
    assign read_strobe_n  = !(in_act && !write_q);
    // low only while write cycle runs
    assign read_not_write = !(busy && write_q);

    wire unused_ok = hold_rq_q & (|cur_lead);
endmodule : ebzi_top

// *** verification/ebzi_checker.sv ***
// Checker: port-level properties of the bus zone sequencer
// Assumes: bound to ebzi_top, one clock domain
`timescale 1ns/1ps
module ebzi_checker (
    // Clock and reset
    input wire logic                        clock,
    input wire logic                        rst_n,
    // Access port
    input wire logic                        req_valid,
    input wire logic                        req_ready,
    input wire logic                        req_pending,
    input wire logic [ebzi_pkg::ZONE_W-1:0] req_zone,
    input wire logic                        rsp_valid,
    input wire logic                        rsp_boot,
    // Mode bit
    input wire logic                        mode_wr,
    input wire logic                        ext_bus_config_two,
    // Hold handshake
    input wire logic                        bus_hold_request_n,
    input wire logic                        bus_hold_grant_n,
    // Pin drive enables
    input wire logic                        strobe_oe,
    input wire logic                        ext_address_bus_oe,
    input wire logic                        ext_data_bus_oe,
    // Selects and strobes
    input wire logic                        read_not_write,
    input wire logic                        chip_select_low_zones_n,
    input wire logic                        chip_select_mid_zone_n,
    input wire logic                        chip_select_high_zones_n,
    input wire logic                        write_strobe_n,
    input wire logic                        read_strobe_n
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic take = req_valid && req_ready;
    wire logic cs_off = chip_select_low_zones_n && chip_select_mid_zone_n
                        && chip_select_high_zones_n;
    wire logic hold_idle = cs_off && !req_pending && !bus_hold_request_n;
    sequence s_hold_ready;
        !bus_hold_request_n && !req_valid && !req_pending && cs_off;
    endsequence
    sequence s_floated;
        !(ext_address_bus_oe || ext_data_bus_oe || strobe_oe);
    endsequence
    a_hold_grant: assert property (s_hold_ready and bus_hold_grant_n |=> !bus_hold_grant_n)
        else $error("hold not granted when idle");
    a_grant_idle: assert property ($fell(bus_hold_grant_n) |-> $past(hold_idle))
        else $error("hold granted while busy");
    a_hold_float: assert property (!bus_hold_grant_n |-> s_floated)
        else $error("bus driven during hold");
    a_grant_release: assert property (bus_hold_request_n && !bus_hold_grant_n |=> bus_hold_grant_n)
        else $error("grant kept after release");
    a_low_select: assert property (take && req_zone <= ebzi_pkg::ZONE_1 |=>
        !chip_select_low_zones_n && chip_select_mid_zone_n)
        else $error("zone 0/1 select missing");
    a_mid_select: assert property (take && req_zone == ebzi_pkg::ZONE_2 |=>
        !chip_select_mid_zone_n && chip_select_high_zones_n)
        else $error("zone 2 select missing");
    a_high_select: assert property (take && (req_zone == ebzi_pkg::ZONE_6 || (req_zone ==
        ebzi_pkg::ZONE_7 && ext_bus_config_two)) |=> !chip_select_high_zones_n)
        else $error("zone 6/7 select missing");
    a_boot_zone: assert property (take && req_zone == ebzi_pkg::ZONE_7 && !ext_bus_config_two
        |=> rsp_valid && rsp_boot && chip_select_high_zones_n)
        else $error("boot access reached the bus");
    a_mode_kept: assert property ($changed(ext_bus_config_two) |-> $past(mode_wr)
        || !$past(rst_n, 2))
        else $error("mode bit changed without write");
    a_rw_exclusive: assert property (read_strobe_n || write_strobe_n)
        else $error("both strobes low");
    a_rnw_level: assert property (strobe_oe && !(write_strobe_n && read_strobe_n) |->
        read_not_write == write_strobe_n)
        else $error("read_not_write wrong for strobe");
    a_data_write: assert property (ext_data_bus_oe |-> !read_not_write && strobe_oe)
        else $error("data driven outside write");
endmodule : ebzi_checker

bind ebzi_top ebzi_checker ebzi_checker_inst (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_pending(req_pending),
    .req_zone(req_zone), .rsp_valid(rsp_valid), .rsp_boot(rsp_boot), .mode_wr(mode_wr),
    .ext_bus_config_two(ext_bus_config_two), .bus_hold_request_n(bus_hold_request_n),
    .bus_hold_grant_n(bus_hold_grant_n), .strobe_oe(strobe_oe),
    .ext_address_bus_oe(ext_address_bus_oe), .ext_data_bus_oe(ext_data_bus_oe),
    .read_not_write(read_not_write), .chip_select_low_zones_n(chip_select_low_zones_n),
    .chip_select_mid_zone_n(chip_select_mid_zone_n), .write_strobe_n(write_strobe_n),
    .chip_select_high_zones_n(chip_select_high_zones_n), .read_strobe_n(read_strobe_n));

// *** verification/ebzi_far_mem.sv ***
// Model: external memory and ready source beyond the bus pins
// Assumes: 16-word store indexed by the low address bits
`timescale 1ns/1ps
module ebzi_far_mem (
    // Clock
    input  wire logic        clock,
    // Bus at the pins
    input  wire logic        strobe_oe,
    input  wire logic        addr_oe,
    input  wire logic        data_oe,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [18:0] addr,
    input  wire logic [15:0] wdata,
    // Answer
    input  wire logic [3:0]  ready_delay,
    output logic [15:0]      rdata,
    output logic             ready
);
    // ****************
    // Store
    // ****************
    logic [15:0] mem [16];
    logic [3:0]  low_cnt = 4'h0;
    wire logic   rd_on = strobe_oe && addr_oe && !rd_n;
    // drive on reads only, pull-up else
    assign rdata = rd_on ? mem[addr[3:0]] : 16'hFFFF;
    assign ready = (low_cnt >= ready_delay);
    always @(posedge clock) begin
        if (strobe_oe && data_oe && !wr_n) mem[addr[3:0]] <= wdata;
        low_cnt <= (strobe_oe && !(rd_n && wr_n)) ? low_cnt + 4'h1 : 4'h0;
    end
endmodule : ebzi_far_mem

// *** verification/ebzi_top_tb_top.sv ***
// Bench: access sequences against the bus zone interface
// Assumes: far side modelled by ebzi_far_mem
`timescale 1ns/1ps
module ebzi_top_tb_top;
    // ****************
    // Stimulus and checks
    // ****************
    logic clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic req_pending = 1'b0, mode_wr = 1'b0, mode_wdata = 1'b0, mode_pin = 1'b1;
    logic hold_n = 1'b1;
    logic [2:0] req_zone = 3'h0;
    logic [18:0] req_addr = 19'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [31:0] lead_len = 32'h11111211, active_len = 32'h11111311;
    logic [31:0] trail_len = 32'h11111111;
    logic [7:0] use_ready = 8'h00, ready_async = 8'h00;
    logic [3:0] ready_delay = 4'h0;
    wire logic req_ready, rsp_valid, rsp_boot, cfg, grant_n, a_oe, d_oe, s_oe;
    wire logic cs_lo, cs_mid, cs_hi, wr_n, rd_n, rnw, rdy;
    wire logic [18:0] addr;
    wire logic [15:0] rsp_rdata, d_o, d_i;
    int fail_count = 0, n_compared = 0, n, ns;
    always #50 clock = ~clock;
    ebzi_top ebzi_top_inst (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_zone(req_zone),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_pending(req_pending),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_boot(rsp_boot),
        .lead_len(lead_len), .active_len(active_len), .trail_len(trail_len),
        .use_ready(use_ready), .ready_async(ready_async), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .ext_bus_config_two(cfg), .zone_top_mode_select(mode_pin),
        .bus_hold_request_n(hold_n), .bus_hold_grant_n(grant_n), .ext_address_bus_o(addr),
        .ext_address_bus_oe(a_oe), .ext_data_bus_i(d_i), .ext_data_bus_o(d_o),
        .ext_data_bus_oe(d_oe), .strobe_oe(s_oe), .chip_select_low_zones_n(cs_lo),
        .chip_select_mid_zone_n(cs_mid), .chip_select_high_zones_n(cs_hi),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .read_not_write(rnw),
        .access_ready(rdy));
    ebzi_far_mem ebzi_far_mem_inst (.clock(clock), .strobe_oe(s_oe), .addr_oe(a_oe),
        .data_oe(d_oe), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(d_o),
        .ready_delay(ready_delay), .rdata(d_i), .ready(rdy));
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic access(input logic w, input logic [2:0] z, input logic [15:0] d);
        int i;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_zone <= z;
        req_addr <= {z == 3'h2, 18'h00005};
        req_wdata <= d;
        i = 0;
        do begin
            @(negedge clock);
            i++;
        end while (req_ready !== 1'b1 && i < 50);
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (rsp_valid !== 1'b1 && n < 50);
        if (i >= 50 || n >= 50) begin
            fail_count++;
            close_out();
        end
    endtask : access
    task automatic wait_grant;
        int i;
        i = 0;
        do begin
            @(negedge clock);
            i++;
        end while (grant_n !== 1'b0 && i < 20);
        check("hold grant", 32'h0, grant_n);
        if (i >= 20) close_out();
    endtask : wait_grant
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        mode_pin <= 1'b0;
        @(negedge clock);
        check("mode bit", 32'h1, cfg);
        access(1'b1, 3'h2, 16'hA5C3);
        check("zone 2 write cycles", 32'h7, n);
        check("zone 2 address", 32'h40005, addr);
        access(1'b0, 3'h0, 16'h0000);
        check("zone 0 read cycles", 32'h4, n);
        check("read data", 32'hA5C3, rsp_rdata);
        access(1'b0, 3'h7, 16'h0000);
        check("zone 7 external", 32'h0, rsp_boot);
        check("zone 7 data", 32'hA5C3, rsp_rdata);
        @(posedge clock);
        mode_wr <= 1'b1;
        @(posedge clock);
        mode_wr <= 1'b0;
        access(1'b0, 3'h7, 16'h0000);
        check("boot cycles", 32'h1, n);
        check("boot flag", 32'h1, rsp_boot);
        @(posedge clock);
        use_ready <= 8'h40;
        ready_delay <= 4'h3;
        access(1'b0, 3'h6, 16'h0000);
        ns = n;
        check("ready stretch", 32'h7, ns);
        @(posedge clock);
        ready_async <= 8'h40;
        access(1'b0, 3'h6, 16'h0000);
        check("async ready cycles", ns + 2, n);
        fork
            access(1'b0, 3'h1, 16'h0000);
            begin
                repeat (2) @(posedge clock);
                hold_n <= 1'b0;
            end
        join
        check("grant during access", 32'h1, grant_n);
        wait_grant();
        check("enables in hold", 32'h0, {a_oe, d_oe, s_oe});
        @(posedge clock);
        hold_n <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        check("grant after release", 32'h1, grant_n);
        @(posedge clock);
        req_pending <= 1'b1;
        hold_n <= 1'b0;
        repeat (5) @(negedge clock);
        check("grant while queued", 32'h1, grant_n);
        @(posedge clock);
        req_pending <= 1'b0;
        wait_grant();
        close_out();
    end
endmodule : ebzi_top_tb_top
